// ---- buck_two_cfg.svh ----
`ifndef BUCK_TWO_CFG_SVH
`define BUCK_TWO_CFG_SVH

// ==========================================================
// Register offsets
`define ADDR_NORMAL_SP 8'h35
`define ADDR_STANDBY_SP 8'h36
`define ADDR_SLEEP_SP 8'h37
`define ADDR_SWITCH_MODE 8'h38
`define ADDR_REG_CONFIG 8'h39

// ==========================================================
// Field positions
`define SP_CODE_MSB 5
`define RANGE_BIT 6
`define MODE_MSB 3
`define SLEEP_SEL_BIT 5
`define ILIM_BIT 0
`define FREQ_LSB 2
`define PHASE_LSB 4
`define RAMP_LSB 6

// ==========================================================
// Reset values
`define STANDBY_SP_RST 6'h00
`define SLEEP_SP_RST 6'h00
`define MODE_RST 4'h8
`define SLEEP_SEL_RST 1'b0
`define ILIM_RST 1'b0
`define FREQ_RST 2'h0
`define PHASE_RST 2'h0
`define RAMP_RST 2'h0
`define RANGE_RST 1'b0
`define NORMAL_SP_RST 6'h00

// ==========================================================
// Voltage decode, millivolts
`define LOW_BASE_MV 12'h190
`define LOW_STEP_MV 12'h019
`define HIGH_BASE_MV 12'h320
`define HIGH_STEP_MV 12'h032
`define HIGH_LAST_CODE 6'h32

`endif

// ---- buck_two_pkg.sv ----
package buck_two_pkg;

    typedef enum logic [2:0] {
        ST_NORMAL = 3'b001,
        ST_STANDBY = 3'b010,
        ST_SLEEP = 3'b100
    } op_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic load;
        logic range_high;
        logic [5:0] normal_sp;
    } cfg_load_t;

    typedef struct packed {
        logic range_high;
        logic [11:0] target_mv;
        logic code_reserved;
        logic reg_enable;
        logic pfm_force;
        logic [3:0] switch_mode;
        logic current_limit_low;
        logic [1:0] switching_freq;
        logic [1:0] phase_clock;
        logic [1:0] voltage_ramp_speed;
    } reg_ctrl_t;

    typedef struct packed {
        reg_ctrl_t ctrl;
        logic [5:0] sp_normal;
        logic [5:0] sp_standby;
        logic [5:0] sp_sleep;
        logic sleep_pfm;
        logic [7:0] rdata;
    } bank_state_t;

endpackage

// ---- buck_two_control_registers.sv ----
`timescale 1ns/10ps
`include "buck_two_cfg.svh"

// Summary of operation
// - Range bit of normal set point is read-only; only configuration load sets it.
// - Range bit 0 gives 0.400 V to 1.975 V in 25 mV steps.
// - Range bit 1 gives 0.800 V to 3.300 V in 50 mV steps.
// - Three six-bit set points; the one matching the operating state applies.
// - Range bit is mirrored read-only into standby and sleep set points.
// - High codes above 1110010 are reserved and flagged.
// - Set points at 0x35 to 0x37, mode at 0x38, configuration at 0x39.
// - Switching mode field bits 3:0 of mode register, reset 0x08.
// - Mode bit 5 picks sleep behaviour: 0 off, 1 pulse-frequency.
// - Configuration bit 0 selects low current limit when set, reset 0.
// - Configuration bits 3:2 hold switching frequency, reset 0.
// - Configuration bits 5:4 hold phase clock selection, reset 0.
// - Configuration bits 7:6 hold voltage ramp speed, reset 0.
// - Standby and sleep set points reset to zero and stay writable.
module buck_two_control_registers
    import buck_two_pkg::*;
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire reg_req_t REG_REQ,
    input wire cfg_load_t CFG,
    input wire op_state_t OP_STATE,
    output logic [7:0] REG_RDATA,
    output reg_ctrl_t CTRL
);

    // ==========================================================
    // Decode helpers
    function automatic logic [11:0] volt_mv(input logic range_high, input logic [5:0] code);
        logic [11:0] c;
        c = {6'h00, code};
        if (range_high) begin
            volt_mv = 12'(`HIGH_BASE_MV + c * `HIGH_STEP_MV);
        end else begin
            volt_mv = 12'(`LOW_BASE_MV + c * `LOW_STEP_MV);
        end
    endfunction

    function automatic logic code_bad(input logic range_high, input logic [5:0] code);
        code_bad = range_high && (code > `HIGH_LAST_CODE);
    endfunction

    bank_state_t s_q;
    bank_state_t s_d;
    logic [5:0] active_sp;

    // ==========================================================
    // Next state
    always_comb begin
        s_d = s_q;
        active_sp = s_q.sp_normal;
        // Host writes touch writable fields only; range and unused bits drop
        if (REG_REQ.wr) begin
            unique case (REG_REQ.addr)
                `ADDR_NORMAL_SP: begin
                    s_d.sp_normal = REG_REQ.wdata[`SP_CODE_MSB:0];
                end
                `ADDR_STANDBY_SP: begin
                    s_d.sp_standby = REG_REQ.wdata[`SP_CODE_MSB:0];
                end
                `ADDR_SLEEP_SP: begin
                    s_d.sp_sleep = REG_REQ.wdata[`SP_CODE_MSB:0];
                end
                `ADDR_SWITCH_MODE: begin
                    s_d.ctrl.switch_mode = REG_REQ.wdata[`MODE_MSB:0];
                    s_d.sleep_pfm = REG_REQ.wdata[`SLEEP_SEL_BIT];
                end
                `ADDR_REG_CONFIG: begin
                    s_d.ctrl.current_limit_low = REG_REQ.wdata[`ILIM_BIT];
                    s_d.ctrl.switching_freq = REG_REQ.wdata[`FREQ_LSB +: 2];
                    s_d.ctrl.phase_clock = REG_REQ.wdata[`PHASE_LSB +: 2];
                    s_d.ctrl.voltage_ramp_speed = REG_REQ.wdata[`RAMP_LSB +: 2];
                end
                default: begin
                end
            endcase
        end
        // Configuration load wins over a host write in the same cycle
        if (CFG.load) begin
            s_d.ctrl.range_high = CFG.range_high;
            s_d.sp_normal = CFG.normal_sp;
        end
        // Read data is the pre-write view
        if (REG_REQ.rd) begin
            unique case (REG_REQ.addr)
                `ADDR_NORMAL_SP: s_d.rdata = {1'b0, s_q.ctrl.range_high, s_q.sp_normal};
                `ADDR_STANDBY_SP: s_d.rdata = {1'b0, s_q.ctrl.range_high, s_q.sp_standby};
                `ADDR_SLEEP_SP: s_d.rdata = {1'b0, s_q.ctrl.range_high, s_q.sp_sleep};
                `ADDR_SWITCH_MODE: s_d.rdata = {2'b00, s_q.sleep_pfm, 1'b0, s_q.ctrl.switch_mode};
                `ADDR_REG_CONFIG: s_d.rdata = {s_q.ctrl.voltage_ramp_speed, s_q.ctrl.phase_clock,
                                                 s_q.ctrl.switching_freq, 1'b0, s_q.ctrl.current_limit_low};
                default: s_d.rdata = 8'h00;
            endcase
        end
        // Operating state picks its set point
        unique case (OP_STATE)
            ST_NORMAL: begin
                active_sp = s_q.sp_normal;
                s_d.ctrl.reg_enable = 1'b1;
                s_d.ctrl.pfm_force = 1'b0;
            end
            ST_STANDBY: begin
                active_sp = s_q.sp_standby;
                s_d.ctrl.reg_enable = 1'b1;
                s_d.ctrl.pfm_force = 1'b0;
            end
            ST_SLEEP: begin
                active_sp = s_q.sp_sleep;
                s_d.ctrl.reg_enable = s_q.sleep_pfm;
                s_d.ctrl.pfm_force = s_q.sleep_pfm;
            end
            default: begin
                // Illegal state code: regulator off, safest choice
                active_sp = s_q.sp_normal;
                s_d.ctrl.reg_enable = 1'b0;
                s_d.ctrl.pfm_force = 1'b0;
            end
        endcase
        // Reserved code holds the last legal target rather than overshoot
        s_d.ctrl.code_reserved = code_bad(s_q.ctrl.range_high, active_sp);
        if (!code_bad(s_q.ctrl.range_high, active_sp)) begin
            s_d.ctrl.target_mv = volt_mv(s_q.ctrl.range_high, active_sp);
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s_q.ctrl.range_high <= `RANGE_RST;
            s_q.ctrl.target_mv <= `LOW_BASE_MV;
            s_q.ctrl.code_reserved <= 1'b0;
            s_q.ctrl.reg_enable <= 1'b0;
            s_q.ctrl.pfm_force <= 1'b0;
            s_q.ctrl.switch_mode <= `MODE_RST;
            s_q.ctrl.current_limit_low <= `ILIM_RST;
            s_q.ctrl.switching_freq <= `FREQ_RST;
            s_q.ctrl.phase_clock <= `PHASE_RST;
            s_q.ctrl.voltage_ramp_speed <= `RAMP_RST;
            s_q.sp_normal <= `NORMAL_SP_RST;
            s_q.sp_standby <= `STANDBY_SP_RST;
            s_q.sp_sleep <= `SLEEP_SP_RST;
            s_q.sleep_pfm <= `SLEEP_SEL_RST;
            s_q.rdata <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    assign REG_RDATA = s_q.rdata;
    assign CTRL = s_q.ctrl;

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    a_range_read_only: assert property (
        !CFG.load |=> $stable(CTRL.range_high))
        else $error("range bit changed without configuration load");

    a_low_window: assert property (
        !CTRL.range_high && $past(!CTRL.range_high) |-> CTRL.target_mv >= 12'h190 && CTRL.target_mv <= 12'h7b7)
        else $error("low range target out of window");

    a_high_window: assert property (
        CTRL.range_high && $past(CTRL.range_high) |-> CTRL.target_mv >= 12'h320 && CTRL.target_mv <= 12'hce4)
        else $error("high range target out of window");

    a_standby_pick: assert property (
        OP_STATE == ST_STANDBY && !code_bad(CTRL.range_high, s_q.sp_standby)
        |=> CTRL.target_mv == volt_mv($past(CTRL.range_high), $past(s_q.sp_standby)) && CTRL.reg_enable)
        else $error("standby target not taken from standby set point");

    a_range_mirror: assert property (
        REG_REQ.rd && REG_REQ.addr == 8'h37 |=> REG_RDATA[6] == $past(CTRL.range_high) && !REG_RDATA[7])
        else $error("sleep set point range copy wrong");

    a_reserved_flag: assert property (
        OP_STATE == ST_NORMAL && CTRL.range_high && s_q.sp_normal > 6'h32
        |=> CTRL.code_reserved && $stable(CTRL.target_mv))
        else $error("reserved code not flagged or target moved");

    a_mode_readback: assert property (
        REG_REQ.wr && REG_REQ.addr == 8'h38 ##1 REG_REQ.rd && REG_REQ.addr == 8'h38 && !REG_REQ.wr
        |=> REG_RDATA == ($past(REG_REQ.wdata, 2) & 8'h2f))
        else $error("mode register readback wrong");

    a_conf_write: assert property (
        REG_REQ.wr && REG_REQ.addr == 8'h39
        |=> {CTRL.voltage_ramp_speed, CTRL.phase_clock, CTRL.switching_freq, CTRL.current_limit_low}
            == {$past(REG_REQ.wdata[7:2]), $past(REG_REQ.wdata[0])})
        else $error("configuration fields not written");

    a_standby_write: assert property (
        REG_REQ.wr && REG_REQ.addr == 8'h36 |=> s_q.sp_standby == $past(REG_REQ.wdata[5:0]))
        else $error("standby set point not written");

    a_sleep_off: assert property (
        OP_STATE == ST_SLEEP && !s_q.sleep_pfm |=> !CTRL.reg_enable && !CTRL.pfm_force)
        else $error("regulator not off in sleep");

    c_sleep_pfm: cover property (OP_STATE == ST_SLEEP && s_q.sleep_pfm ##1 CTRL.pfm_force);
    c_high_reserved: cover property (CTRL.range_high ##1 CTRL.code_reserved);
    c_state_walk: cover property (OP_STATE == ST_NORMAL ##1 OP_STATE == ST_STANDBY ##1 OP_STATE == ST_SLEEP);

endmodule

// ---- reg_host_model.sv ----
`timescale 1ns/10ps
// ==========================================================
// Host side of the register port
module reg_host_model
    import buck_two_pkg::*;
(
    input wire logic CLK,
    input wire logic [7:0] RDATA,
    output reg_req_t REQ
);
    initial REQ = '0;

    // Targets kept legal: high range 2.0 V up, low range above 0.6 V
    function automatic logic [5:0] legal_code(input int rh, input int unsigned r);
        return (rh != 0) ? 6'(24 + r % 27) : 6'(9 + r % 55);
    endfunction

    // Released address and data flip so a stale value never passes
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        REQ <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge CLK);
        REQ <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge CLK);
        REQ <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: REQ.wdata};
        @(posedge CLK);
        REQ <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~REQ.wdata};
        #1 d = RDATA;
    endtask

    // Write then read the same register with no idle cycle between
    task automatic write_read(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge CLK);
        REQ <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge CLK);
        REQ <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: ~d};
        @(posedge CLK);
        REQ <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: d};
        #1 q = RDATA;
    endtask
endmodule

// ---- buck_two_control_registers_tb_top.sv ----
`timescale 1ns/10ps
module buck_two_control_registers_tb_top;
    import buck_two_pkg::*;
    logic CLK;
    logic ARST_N;
    reg_req_t REG_REQ;
    cfg_load_t CFG;
    op_state_t OP_STATE;
    logic [7:0] REG_RDATA;
    reg_ctrl_t CTRL;
    int bad_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int sp[3] = '{0, 0, 0};
    int rng = 0, mode = 8, slp = 0, conf = 0;
    op_state_t sts[4] = '{ST_NORMAL, ST_STANDBY, ST_SLEEP, op_state_t'(3'b011)};
    int exp_mv = 400;

    buck_two_control_registers uut (.CLK(CLK), .ARST_N(ARST_N), .REG_REQ(REG_REQ), .CFG(CFG),
        .OP_STATE(OP_STATE), .REG_RDATA(REG_RDATA), .CTRL(CTRL));
    reg_host_model host (.CLK(CLK), .RDATA(REG_RDATA), .REQ(REG_REQ));

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    // ==========================================================
    // Reference model
    function automatic int rd_exp(input int a);
        case (a)
            'h35: return (rng << 6) | sp[0];
            'h36: return (rng << 6) | sp[1];
            'h37: return (rng << 6) | sp[2];
            'h38: return (slp << 5) | mode;
            'h39: return conf;
            default: return 0;
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("mismatches %0d, comparisons %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Model drops read-only and unused bits
    task automatic wr(input int a, input logic [7:0] d, input bit back = 1'b0);
        logic [7:0] q;
        if (back)
            host.write_read(8'(a), d, q);
        else
            host.write_reg(8'(a), d);
        case (a)
            'h35: sp[0] = d & 'h3F;
            'h36: sp[1] = d & 'h3F;
            'h37: sp[2] = d & 'h3F;
            'h38: begin mode = d & 'hF; slp = (d >> 5) & 1; end
            'h39: conf = d & 'hFD;
            default: ;
        endcase
        if (back)
            check(q, rd_exp(a));
    endtask

    task automatic rd_all();
        logic [7:0] v;
        for (int a = 'h34; a <= 'h3A; a++) begin
            host.read_reg(8'(a), v);
            check(v, rd_exp(a));
        end
        check({CTRL.voltage_ramp_speed, CTRL.phase_clock, CTRL.switching_freq, 1'b0, CTRL.current_limit_low},
            conf);
        check(CTRL.switch_mode, mode);
    endtask

    // Target due after the next edge; a reserved code keeps the last legal one
    always @(negedge CLK) begin
        int k;
        k = (OP_STATE == ST_STANDBY) ? 1 : (OP_STATE == ST_SLEEP) ? 2 : 0;
        if (rng == 0 || sp[k] <= 50)
            exp_mv = (rng != 0) ? 800 + 50 * sp[k] : 400 + 25 * sp[k];
    end

    // Index 3 is an illegal state code: regulator off, normal set point
    task automatic st_chk(input int i);
        int k;
        k = (i == 3) ? 0 : i;
        @(posedge CLK) OP_STATE <= sts[i];
        repeat (3) @(posedge CLK);
        #1;
        check(CTRL.reg_enable, (i == 2) ? slp : (i != 3));
        check(CTRL.pfm_force, (i == 2) && slp);
        check(CTRL.range_high, rng);
        check(CTRL.target_mv, exp_mv);
        check(CTRL.code_reserved, rng && sp[k] > 50);
    endtask

    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        ARST_N = 1'b0;
        CFG = '0;
        OP_STATE = ST_NORMAL;
        void'($urandom(32'h945c906c));
        repeat (8) @(posedge CLK);
        ARST_N <= 1'b1;
        rd_all();
        st_chk(0);
        for (int r = 0; r < 2; r++) begin
            @(posedge CLK) CFG <= '{load: 1'b1, range_high: r[0], normal_sp: 6'h20};
            @(posedge CLK) CFG.load <= 1'b0;
            rng = r;
            sp[0] = 'h20;
            // All ones: ignored bits, and a reserved code in high range
            for (int a = 'h35; a <= 'h3A; a++) wr(a, 8'hFF);
            rd_all();
            st_chk(0);
            st_chk(2);
            repeat (6) begin
                for (int i = 0; i < 3; i++)
                    wr('h35 + i, {2'($urandom_range(3, 0)), host.legal_code(rng, $urandom)});
                wr('h38, 8'($urandom), 1'b1);
                wr('h39, 8'($urandom), 1'b1);
                rd_all();
                for (int i = 0; i < 4; i++) st_chk(i);
            end
        end
        results();
    end
endmodule
